/* File: rtl/pll_synth_defines.vh */
// Purpose: Register offsets, field positions, reset values and timing counts of the PLL synthesizer core.
// Assumes: Included by its bare name; definitions only.
// Notes: Offsets are register addresses on the plain register port; each one selects a whole 16-bit register.
`ifndef PLL_SYNTH_DEFINES_VH
`define PLL_SYNTH_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_UNLOCK_JUDGE 8'h05
`define OFS_UNLOCK_SENS 8'h15
`define OFS_MODE_SELECT 8'h21
`define OFS_REF_RATE 8'h31
`define OFS_DIV_RATIO 8'h41
`define OFS_IRQ_STATUS 8'h50
`define OFS_IRQ_MASK 8'h51

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define MODE_OFF 2'b00
`define MODE_DIRECT_LOW 2'b01
`define MODE_SWALLOW_HIGH 2'b10
`define MODE_SWALLOW_LOW 2'b11
`define RATIO_PROG_MSB 15
`define RATIO_PROG_LSB 4
`define RATIO_SWAL_MSB 3
`define RATIO_SWAL_LSB 0
`define IRQ_BIT_UNLOCK 0
`define IRQ_BIT_RELOAD 1
`define RST_NIBBLE 4'h0
`define RST_RATIO 16'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define PRESCALE_LOW 5'h0f
`define PRESCALE_HIGH 5'h10
// Phase error widths, in ns, that mark the loop as unlocked for each sensitivity.
`define UNLOCK_NS_0 40
`define UNLOCK_NS_1 160
`define UNLOCK_NS_2 640
`define UNLOCK_NS_3 2560

`endif

/* File: rtl/pll_synth_divider_control.v */
// Purpose: Digital core of a PLL frequency synthesizer: input select, divider, reference, comparator, pump, unlock.
// Assumes: All inputs synchronous to clock_i; oscillator inputs are already sampled logic levels.
// Notes: Pump pins are three-state: value, and an enable that is low while the pin is driven.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
`include "pll_synth_defines.vh"

// Functional notes
// RULE1: The synthesizer runs only while the operate-enable input is high.
// RULE2: With the operate-enable input low, every part of the synthesizer is held in its disabled state.
// RULE3: The mode register picks whether the high-band or low-band oscillator input feeds the divider.
// RULE4: The mode register picks direct division or pulse-swallow division.
// RULE5: The divider takes its ratio from the division ratio register written by software.
// RULE6: The divider divides the selected input by the programmed ratio and emits the divided pulse.
// RULE7: The reference generator gives one of twelve rates picked by the reference rate register.
// RULE8: The phase comparator turns the divided and reference pulses into a phase difference.
// RULE9: The unlock detector flags loss of lock with a selectable sensitivity, read in the unlock judge register.
// RULE10: The charge pump drives both error pins high, low or floating from the comparator result.
// RULE11: Mode 00 disables both inputs, 01 is direct on low band, 10 swallow on high band, 11 swallow on low band.
// RULE12: The swallow counter is a 4-bit down-counter and the programmable counter a 12-bit down-counter.
// RULE13: The upper 12 ratio bits load the programmable counter and, in swallow mode, the lower 4 the swallow counter.
// RULE14: With both inputs disabled the comparator, reference generator and pump still run.
// RULE15: The pump floats with no phase difference and drives only while the two edges differ.
module pll_synth_divider_control #(
  parameter REF_UNIT_CYCLES = 100
) (
  input wire clock_i,
  input wire srst_i,
  input wire operate_enable_i,
  input wire high_band_osc_input_i,
  input wire low_band_osc_input_i,
  input wire [7:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  output reg loop_error_out_a_o,
  output reg loop_error_out_a_oe_n_o,
  output reg loop_error_out_b_o,
  output reg loop_error_out_b_oe_n_o,
  output reg high_band_select_o,
  output reg low_band_select_o,
  output reg irq_o
);

  // Unlock limits in whole clock cycles; an error width shorter than one clock would round down to zero.
  localparam [11:0] UNLOCK_CYC_0 = `UNLOCK_NS_0 / `CLK_PERIOD_NS;
  localparam [11:0] UNLOCK_CYC_1 = `UNLOCK_NS_1 / `CLK_PERIOD_NS;
  localparam [11:0] UNLOCK_CYC_2 = `UNLOCK_NS_2 / `CLK_PERIOD_NS;
  localparam [11:0] UNLOCK_CYC_3 = `UNLOCK_NS_3 / `CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [3:0] unlock_sens_q;
  reg [3:0] mode_q;
  reg [3:0] ref_rate_q;
  reg [15:0] ratio_q;
  reg unlock_ff_q;
  reg [1:0] irq_status_q;
  reg [1:0] irq_mask_q;

  reg osc_prev_q;
  reg [4:0] pres_cnt_q;
  reg [3:0] swal_cnt_q;
  reg [11:0] prog_cnt_q;
  reg div_pulse_q;
  reg [31:0] ref_cnt_q;
  reg ref_pulse_q;
  reg up_q;
  reg down_q;
  reg [11:0] err_cnt_q;

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  wire run = operate_enable_i; // see RULE1
  wire [1:0] mode = mode_q[1:0];
  wire inputs_on = run && (mode != `MODE_OFF);
  wire swallow = mode[1]; // see RULE4
  wire osc_sel = (mode == `MODE_SWALLOW_HIGH) ? high_band_osc_input_i : low_band_osc_input_i; // see RULE3
  wire osc_edge = inputs_on && osc_sel && !osc_prev_q;
  wire [11:0] ratio_prog = ratio_q[`RATIO_PROG_MSB:`RATIO_PROG_LSB];
  wire [3:0] ratio_swal = ratio_q[`RATIO_SWAL_MSB:`RATIO_SWAL_LSB];
  wire wr_hit_judge = wr_i && (addr_i == `OFS_UNLOCK_JUDGE);
  wire rd_hit_judge = rd_i && (addr_i == `OFS_UNLOCK_JUDGE);

  reg [31:0] ref_period;
  reg [11:0] unlock_limit;
  reg unlock_event;

  // ----------------------------------------------------------------
  // Reference rate and unlock sensitivity tables
  // ----------------------------------------------------------------
  always @*
  begin
    case (ref_rate_q) // see RULE7
      4'h0: ref_period = REF_UNIT_CYCLES * 1000;
      4'h1: ref_period = REF_UNIT_CYCLES * 400;
      4'h2: ref_period = REF_UNIT_CYCLES * 200;
      4'h3: ref_period = REF_UNIT_CYCLES * 160;
      4'h4: ref_period = REF_UNIT_CYCLES * 111;
      4'h5: ref_period = REF_UNIT_CYCLES * 100;
      4'h6: ref_period = REF_UNIT_CYCLES * 80;
      4'h7: ref_period = REF_UNIT_CYCLES * 40;
      4'h8: ref_period = REF_UNIT_CYCLES * 20;
      4'h9: ref_period = REF_UNIT_CYCLES * 10;
      4'ha: ref_period = REF_UNIT_CYCLES * 8;
      4'hb: ref_period = REF_UNIT_CYCLES * 4;
      default: ref_period = REF_UNIT_CYCLES * 1000;
    endcase
    // Only the two low bits of the sensitivity are stored; the upper bits read as zero.
    case (unlock_sens_q[1:0])
      2'b00: unlock_limit = UNLOCK_CYC_0;
      2'b01: unlock_limit = UNLOCK_CYC_1;
      2'b10: unlock_limit = UNLOCK_CYC_2;
      default: unlock_limit = UNLOCK_CYC_3;
    endcase
    unlock_event = run && (up_q ^ down_q) && (err_cnt_q >= unlock_limit); // see RULE9
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always @(posedge clock_i)
  begin
    if (srst_i)
    begin
      unlock_sens_q <= `RST_NIBBLE;
      mode_q <= `RST_NIBBLE;
      ref_rate_q <= `RST_NIBBLE;
      ratio_q <= `RST_RATIO;
      irq_mask_q <= 2'h0;
      rdata_o <= 16'h0000;
    end
    else
    begin
      // A new ratio reaches the counters only at the next terminal count, so a running period is never cut short.
      if (wr_i)
      begin
        case (addr_i)
          `OFS_UNLOCK_SENS: unlock_sens_q <= {2'b00, wdata_i[1:0]};
          `OFS_MODE_SELECT: mode_q <= {2'b00, wdata_i[1:0]}; // see RULE11
          `OFS_REF_RATE: ref_rate_q <= wdata_i[3:0];
          `OFS_DIV_RATIO: ratio_q <= wdata_i; // see RULE5
          `OFS_IRQ_MASK: irq_mask_q <= wdata_i[1:0];
          default: ;
        endcase
      end
      if (rd_i)
      begin
        case (addr_i)
          `OFS_UNLOCK_JUDGE: rdata_o <= {15'h0000, unlock_ff_q};
          `OFS_UNLOCK_SENS: rdata_o <= {12'h000, unlock_sens_q};
          `OFS_MODE_SELECT: rdata_o <= {12'h000, mode_q};
          `OFS_REF_RATE: rdata_o <= {12'h000, ref_rate_q};
          `OFS_DIV_RATIO: rdata_o <= ratio_q;
          `OFS_IRQ_STATUS: rdata_o <= {14'h0000, irq_status_q};
          `OFS_IRQ_MASK: rdata_o <= {14'h0000, irq_mask_q};
          default: rdata_o <= 16'h0000;
        endcase
      end
      else
        rdata_o <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Unlock flag and interrupts
  // ----------------------------------------------------------------
  always @(posedge clock_i)
  begin
    if (srst_i)
    begin
      unlock_ff_q <= 1'b0;
      irq_status_q <= 2'h0;
      irq_o <= 1'b0;
    end
    else
    begin
      // Reading or writing the judge register clears the flag; a new unlock in that cycle wins.
      if (unlock_event)
        unlock_ff_q <= 1'b1; // see RULE9
      else if (rd_hit_judge || wr_hit_judge)
        unlock_ff_q <= 1'b0;
      irq_status_q[`IRQ_BIT_UNLOCK] <= unlock_event ||
        (irq_status_q[`IRQ_BIT_UNLOCK] && !(wr_i && addr_i == `OFS_IRQ_STATUS && wdata_i[`IRQ_BIT_UNLOCK]));
      irq_status_q[`IRQ_BIT_RELOAD] <= div_pulse_q ||
        (irq_status_q[`IRQ_BIT_RELOAD] && !(wr_i && addr_i == `OFS_IRQ_STATUS && wdata_i[`IRQ_BIT_RELOAD]));
      // The interrupt level follows the status one cycle late, like every other output of this block.
      irq_o <= |(irq_status_q & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Input selector and programmable divider
  // ----------------------------------------------------------------
  always @(posedge clock_i)
  begin
    if (srst_i || !inputs_on) // see RULE2
    begin
      osc_prev_q <= 1'b0;
      pres_cnt_q <= 5'h00;
      swal_cnt_q <= 4'h0;
      prog_cnt_q <= 12'h000;
      div_pulse_q <= 1'b0;
      high_band_select_o <= 1'b0;
      low_band_select_o <= 1'b0;
    end
    else
    begin
      osc_prev_q <= osc_sel;
      // The select outputs stand for the pull-down of the unused input: only the selected one is driven.
      high_band_select_o <= (mode == `MODE_SWALLOW_HIGH);
      low_band_select_o <= (mode != `MODE_SWALLOW_HIGH);
      div_pulse_q <= 1'b0;
      // The counters are cleared while the inputs are off, so the first rising input edge reaches terminal count
      // at once and loads the ratio; the divided period is exact from the second pulse on.
      if (osc_edge)
      begin
        if (!swallow || pres_cnt_q == 5'h00)
        begin
          // One prescaler output: the 12-bit counter steps, the 4-bit one steps while it is not zero.
          if (prog_cnt_q <= 12'h001) // see RULE6
          begin
            div_pulse_q <= 1'b1;
            prog_cnt_q <= ratio_prog; // see RULE13
            swal_cnt_q <= swallow ? ratio_swal : 4'h0;
            pres_cnt_q <= (swallow && ratio_swal != 4'h0) ? `PRESCALE_HIGH : `PRESCALE_LOW;
          end
          else
          begin
            prog_cnt_q <= prog_cnt_q - 12'h001; // see RULE12
            if (swal_cnt_q > 4'h1)
              pres_cnt_q <= `PRESCALE_HIGH;
            else
              pres_cnt_q <= `PRESCALE_LOW;
            if (swal_cnt_q != 4'h0)
              swal_cnt_q <= swal_cnt_q - 4'h1;
          end
        end
        else
          pres_cnt_q <= pres_cnt_q - 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reference generator, phase comparator and charge pump
  // ----------------------------------------------------------------
  always @(posedge clock_i)
  begin
    if (srst_i || !run) // see RULE2
    begin
      ref_cnt_q <= 32'h0000_0000;
      ref_pulse_q <= 1'b0;
      up_q <= 1'b0;
      down_q <= 1'b0;
      err_cnt_q <= 12'h000;
      loop_error_out_a_o <= 1'b0;
      loop_error_out_b_o <= 1'b0;
      loop_error_out_a_oe_n_o <= 1'b1;
      loop_error_out_b_oe_n_o <= 1'b1;
    end
    else
    begin
      // These run in mode 00 as well; only the input selector and divider stop there.
      // At-least compare: a switch to a shorter period takes effect within one cycle instead of after a wrap.
      if (ref_cnt_q >= ref_period - 32'h0000_0001) // see RULE14
      begin
        ref_cnt_q <= 32'h0000_0000;
        ref_pulse_q <= 1'b1;
      end
      else
      begin
        ref_cnt_q <= ref_cnt_q + 32'h0000_0001;
        ref_pulse_q <= 1'b0;
      end
      if ((up_q || ref_pulse_q) && (down_q || div_pulse_q)) // see RULE8
      begin
        up_q <= 1'b0;
        down_q <= 1'b0;
      end
      else
      begin
        up_q <= up_q || ref_pulse_q;
        down_q <= down_q || div_pulse_q;
      end
      if (up_q ^ down_q)
      begin
        if (err_cnt_q != 12'hfff)
          err_cnt_q <= err_cnt_q + 12'h001;
      end
      else
        err_cnt_q <= 12'h000;
      // Both pins carry the same level, so either one may drive the loop filter.
      loop_error_out_a_o <= up_q;
      loop_error_out_b_o <= up_q;
      loop_error_out_a_oe_n_o <= !(up_q ^ down_q); // see RULE10
      loop_error_out_b_oe_n_o <= !(up_q ^ down_q); // see RULE15
    end
  end

endmodule // pll_synth_divider_control

/* File: bench/pll_synth_properties.sv */
// Purpose: Port-level properties of the PLL synthesizer core.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Bound to every instance of the core.
`timescale 1ns/100ps
module pll_synth_properties (
  input wire clock_i,
  input wire srst_i,
  input wire operate_enable_i,
  input wire [7:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [15:0] rdata_o,
  input wire loop_error_out_a_o,
  input wire loop_error_out_a_oe_n_o,
  input wire loop_error_out_b_o,
  input wire loop_error_out_b_oe_n_o,
  input wire high_band_select_o,
  input wire low_band_select_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);

  chk_pump_float_off: assert property (!operate_enable_i [*3]
    |-> loop_error_out_a_oe_n_o && loop_error_out_b_oe_n_o)
    else $error("pump driven while disabled");
  chk_select_off: assert property (!operate_enable_i [*2] |-> !high_band_select_o && !low_band_select_o)
    else $error("input selected while disabled");
  chk_select_one: assert property (!(high_band_select_o && low_band_select_o))
    else $error("both inputs selected");
  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data outside read slot");
  chk_unmapped_read: assert property (rd_i && addr_i == 8'h00 |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  chk_pump_pins_pair: assert property (loop_error_out_a_oe_n_o == loop_error_out_b_oe_n_o
    && (loop_error_out_a_oe_n_o || loop_error_out_a_o == loop_error_out_b_o))
    else $error("pump pins disagree");
  chk_mode_readback: assert property (wr_i && addr_i == 8'h21 ##1 rd_i && addr_i == 8'h21
    |=> rdata_o == ($past(wdata_i, 2) & 16'h0003))
    else $error("mode readback wrong");
  chk_select_high: assert property (wr_i && addr_i == 8'h21 && wdata_i[1:0] == 2'b10
    && operate_enable_i ##1 operate_enable_i [*2] |-> high_band_select_o && !low_band_select_o)
    else $error("high band not selected");
  chk_select_low: assert property (wr_i && addr_i == 8'h21 && wdata_i[0] && operate_enable_i
    ##1 operate_enable_i [*2] |-> low_band_select_o && !high_band_select_o)
    else $error("low band not selected");
endmodule // pll_synth_properties

bind pll_synth_divider_control pll_synth_properties u_props (
  .clock_i(clock_i), .srst_i(srst_i), .operate_enable_i(operate_enable_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .loop_error_out_a_o(loop_error_out_a_o), .loop_error_out_a_oe_n_o(loop_error_out_a_oe_n_o),
  .loop_error_out_b_o(loop_error_out_b_o), .loop_error_out_b_oe_n_o(loop_error_out_b_oe_n_o),
  .high_band_select_o(high_band_select_o), .low_band_select_o(low_band_select_o));

/* File: bench/vco_model.sv */
// Purpose: Behavioural oscillator feeding the selected band input.
// Assumes: Half period given in clock cycles, at least one.
// Notes: A larger half period models a slow oscillator.
`timescale 1ns/100ps
module vco_model (
  input wire logic clock_i,
  input wire logic high_band_select_i,
  input wire logic low_band_select_i,
  input wire logic [7:0] half_i,
  output logic high_band_osc_o,
  output logic low_band_osc_o
);
  logic [7:0] cnt_q = 8'h00;
  logic wave_q = 1'b0;
  always @(posedge clock_i)
  begin
    if (cnt_q + 8'h01 >= half_i)
    begin
      cnt_q <= 8'h00;
      wave_q <= ~wave_q;
    end
    else
      cnt_q <= cnt_q + 8'h01;
  end
  // An input that is not in use is pulled down.
  assign high_band_osc_o = high_band_select_i & wave_q;
  assign low_band_osc_o = low_band_select_i & wave_q;
endmodule // vco_model

/* File: bench/testbench.sv */
// Purpose: Register-level tests of the PLL synthesizer core.
// Assumes: Reference unit shortened to one clock cycle.
// Notes: Oscillator half period is two cycles.
`timescale 1ns/100ps
`include "pll_synth_defines.vh"
module testbench;
  logic clock_i, srst_i, en, wr_i, rd_i, irq, hb, lb, ea, ea_n, hi, lo;
  logic [7:0] addr_i;
  logic [15:0] wdata_i, rdata, v;
  int fails, comparisons, m, per;
  logic [7:0] ofs [7] = '{`OFS_UNLOCK_JUDGE, `OFS_UNLOCK_SENS, `OFS_MODE_SELECT, `OFS_REF_RATE,
    `OFS_DIV_RATIO, `OFS_IRQ_STATUS, `OFS_IRQ_MASK};
  pll_synth_divider_control #(.REF_UNIT_CYCLES(1)) DUT (.clock_i(clock_i), .srst_i(srst_i),
    .operate_enable_i(en), .high_band_osc_input_i(hi), .low_band_osc_input_i(lo), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .loop_error_out_a_o(ea),
    .loop_error_out_a_oe_n_o(ea_n), .loop_error_out_b_o(), .loop_error_out_b_oe_n_o(),
    .high_band_select_o(hb), .low_band_select_o(lb), .irq_o(irq));
  vco_model u_vco (.clock_i(clock_i), .high_band_select_i(hb), .low_band_select_i(lb), .half_i(8'h02),
    .high_band_osc_o(hi), .low_band_osc_o(lo));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  end
  endtask
  // Tasks are entered at a rising edge; a write strobe stays up until the next task lowers it.
  task wt(input int n);
  begin
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (n) @(posedge clock_i);
  end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
  begin
    rd_i <= 1'b0;
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
  end
  endtask
  task rd(input logic [7:0] a, output logic [15:0] d);
  begin
    wr_i <= 1'b0;
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(posedge clock_i);
    d = rdata;
  end
  endtask
  task rc(input logic [7:0] a, input logic [15:0] e);
  begin
    rd(a, v);
    chk(v, e);
  end
  endtask
  task final_report;
  begin
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  initial
  begin
    clock_i = 0;
    forever #5 clock_i = ~clock_i;
  end
  initial
  begin
    #50000 fails = fails + 1;
    final_report();
  end
  initial
  begin
    fails = 0;
    comparisons = 0;
    srst_i <= 1'b1;
    en <= 1'b0;
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    addr_i <= 8'h00;
    wdata_i <= 16'h0000;
    repeat (12) @(posedge clock_i);
    srst_i <= 1'b0;
    wt(1);
    for (m = 0; m < 7; m++) rc(ofs[m], 16'h0000);
    rc(8'h00, 16'h0000);
    wr(`OFS_UNLOCK_SENS, 16'hffff);
    rc(`OFS_UNLOCK_SENS, 16'h0003);
    wr(`OFS_REF_RATE, 16'hffff);
    rc(`OFS_REF_RATE, 16'h000f);
    wr(`OFS_DIV_RATIO, 16'ha5c3);
    rc(`OFS_DIV_RATIO, 16'ha5c3);
    wr(8'h60, 16'hffff);
    rc(8'h60, 16'h0000);
    en <= 1'b1;
    for (m = 0; m < 4; m++)
    begin
      wr(`OFS_MODE_SELECT, m[15:0]);
      rc(`OFS_MODE_SELECT, m[15:0]);
      wt(3);
      chk({14'h0000, hb, lb}, {14'h0000, m == 2, m[0]});
    end
    wr(`OFS_MODE_SELECT, 16'h0000);
    wr(`OFS_REF_RATE, 16'h000b);
    wr(`OFS_UNLOCK_SENS, 16'h0000);
    wr(`OFS_IRQ_MASK, 16'h0003);
    wr(`OFS_IRQ_STATUS, 16'h0002);
    wt(20);
    chk({14'h0000, ea_n, ea}, 16'h0001);
    rc(`OFS_UNLOCK_JUDGE, 16'h0001);
    chk({15'h0000, irq}, 16'h0001);
    rd(`OFS_IRQ_STATUS, v);
    chk(v & 16'h0002, 16'h0000);
    en <= 1'b0;
    wt(4);
    chk({13'h0000, ea_n, hb, lb}, 16'h0004);
    wr(`OFS_IRQ_STATUS, 16'h0003);
    rc(`OFS_IRQ_STATUS, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    rc(`OFS_UNLOCK_JUDGE, 16'h0001);
    rc(`OFS_UNLOCK_JUDGE, 16'h0000);
    // Divided period in clocks: ratio edges times the four-clock oscillator period.
    for (m = 1; m < 4; m++)
    begin
      per = (m == 1) ? 64 : (m == 2) ? 256 : 260;
      wr(`OFS_DIV_RATIO, (m == 1) ? 16'h0100 : (m == 2) ? 16'h0040 : 16'h0041);
      wr(`OFS_MODE_SELECT, m[15:0]);
      en <= 1'b1;
      wt(16);
      wr(`OFS_IRQ_STATUS, 16'h0002);
      wt(per / 2);
      rd(`OFS_IRQ_STATUS, v);
      chk(v & 16'h0002, 16'h0000);
      wt(per);
      rd(`OFS_IRQ_STATUS, v);
      chk(v & 16'h0002, 16'h0002);
      en <= 1'b0;
      wt(2);
    end
    en <= 1'b1;
    chk({15'h0000, irq}, 16'h0001);
    wr(`OFS_IRQ_MASK, 16'h0000);
    wt(2);
    chk({15'h0000, irq}, 16'h0000);
    final_report();
  end
endmodule // testbench
